// *** shared/buckboost_cfg.svh ***
`ifndef BUCKBOOST_CFG_SVH
`define BUCKBOOST_CFG_SVH
// Register byte addresses
`define BB_CONTROL_ADDR 8'h2b
`define BB_VOLTAGE_DELAY_ADDR 8'h2c
// Control register field positions
`define BB_SS_MSB 7
`define BB_SS_LSB 6
`define BB_ILIM_MSB 5
`define BB_ILIM_LSB 3
`define BB_STOP_BIT 2
`define BB_DISCHG_BIT 1
`define BB_EN_BIT 0
// Voltage and delay register field positions
`define BB_DLY_MSB 7
`define BB_DLY_LSB 6
`define BB_VOUT_MSB 5
`define BB_VOUT_LSB 0
// Fixed reset values
`define BB_ILIM_RESET 3'h3
`define BB_STOP_RESET 1'h0
`define BB_DLY_RESET 2'h0
// Voltage scale, millivolts
`define BB_VOUT_KNEE_CODE 6'h0c
`define BB_VOUT_LOW_BASE_MV 16'd1800
`define BB_VOUT_LOW_STEP_MV 16'd100
`define BB_VOUT_HIGH_BASE_MV 16'd2950
`define BB_VOUT_HIGH_STEP_MV 16'd50
// Current limit step, milliamps
`define BB_ILIM_STEP_MA 16'd100
`endif

// *** shared/buckboost_pkg.sv ***
package buckboost_pkg;
  // Control register layout
  typedef struct packed {
    logic [1:0] softstart_time_sel;
    logic [2:0] peak_current_limit_sel;
    logic pulse_stop_enable;
    logic output_discharge_enable;
    logic regulator_output_enable;
  } control_reg_t;
  // Voltage and delay register layout
  typedef struct packed {
    logic [1:0] hysteresis_switch_delay_sel;
    logic [5:0] output_voltage_code;
  } voltage_delay_reg_t;
endpackage : buckboost_pkg

// *** core/buckboost_config_regs.sv ***
// How it works
// R1: Soft start code 00..11 selects 1, 8, 64 or 512 ms ramp.
// R2: Peak current limit is 100 mA times code plus one; resets to 011.
// R3: Control bit two enables pulse stop; clear after reset.
// R4: Control bit one enables output discharge; factory reset value.
// R5: Control bit zero turns regulator output on; factory reset value.
// R6: Switch delay code selects 0, 5, 10 or 20 us; resets to zero.
// R7: Voltage codes 0..11 give 1.8 V plus 100 mV per step.
// R8: Voltage codes 12..63 give 2.95 V plus 50 mV per step.
// R9: Factory fields load from parameters; writable fields read back last write.
`timescale 1ns/1ps
`default_nettype none
`include "buckboost_cfg.svh"
module buckboost_config_regs #(
  parameter logic [1:0] SOFTSTART_RESET = 2'h0,
  parameter logic DISCHARGE_RESET = 1'h0,
  parameter logic OUTPUT_ENABLE_RESET = 1'h0,
  parameter logic [5:0] VOUT_CODE_RESET = 6'h00
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic [1:0] softstart_time_sel_o,
  output logic [15:0] softstart_time_ms_o,
  output logic [2:0] peak_current_limit_sel_o,
  output logic [15:0] peak_current_limit_ma_o,
  output logic pulse_stop_enable_o,
  output logic output_discharge_enable_o,
  output logic regulator_output_enable_o,
  output logic [1:0] hysteresis_switch_delay_sel_o,
  output logic [7:0] hysteresis_switch_delay_us_o,
  output logic [5:0] output_voltage_code_o,
  output logic [15:0] output_voltage_mv_o
);

  // Stored fields and their next values
  logic [1:0] softstart_q;
  logic [1:0] softstart_d;
  logic [2:0] current_limit_q;
  logic [2:0] current_limit_d;
  logic pulse_stop_q;
  logic pulse_stop_d;
  logic discharge_q;
  logic discharge_d;
  logic output_enable_q;
  logic output_enable_d;
  logic [1:0] switch_delay_q;
  logic [1:0] switch_delay_d;
  logic [5:0] vout_code_q;
  logic [5:0] vout_code_d;

  // Write byte split by each register layout
  buckboost_pkg::control_reg_t control_wr;
  buckboost_pkg::voltage_delay_reg_t volt_dly_wr;

  // Stored fields packed back into register layout for readback
  buckboost_pkg::control_reg_t control_rd;
  buckboost_pkg::voltage_delay_reg_t volt_dly_rd;

  // Register select and write strobes
  wire logic sel_control = (addr_i == `BB_CONTROL_ADDR);
  wire logic sel_volt_dly = (addr_i == `BB_VOLTAGE_DELAY_ADDR);
  wire logic wr_control = wr_en_i && sel_control;
  wire logic wr_volt_dly = wr_en_i && sel_volt_dly;

  // Soft start ramp, each code step is a factor of eight
  function automatic logic [15:0] softstart_ms(input logic [1:0] code);
    case (code)
      2'h0: softstart_ms = 16'h0001;
      2'h1: softstart_ms = 16'h0008;
      2'h2: softstart_ms = 16'h0040;
      2'h3: softstart_ms = 16'h0200;
      default: softstart_ms = 16'h0001;
    endcase
  endfunction : softstart_ms

  // Peak current limit, code zero already gives one step
  function automatic logic [15:0] ilim_ma(input logic [2:0] code);
    logic [15:0] steps;
    steps = {13'h0000, code} + 16'h0001;
    ilim_ma = 16'(steps * `BB_ILIM_STEP_MA);
  endfunction : ilim_ma

  // Switch delay in hysteresis, doubling above the first step
  function automatic logic [7:0] delay_us(input logic [1:0] code);
    case (code)
      2'h0: delay_us = 8'h00;
      2'h1: delay_us = 8'h05;
      2'h2: delay_us = 8'h0a;
      2'h3: delay_us = 8'h14;
      default: delay_us = 8'h00;
    endcase
  endfunction : delay_us

  // Two-segment voltage scale in millivolts
  function automatic logic [15:0] vout_mv(input logic [5:0] code);
    logic [15:0] c;
    logic [15:0] above_knee;
    c = {10'h000, code};
    above_knee = c - {10'h000, `BB_VOUT_KNEE_CODE};
    if (code < `BB_VOUT_KNEE_CODE) begin
      vout_mv = `BB_VOUT_LOW_BASE_MV + 16'(c * `BB_VOUT_LOW_STEP_MV); // see R7
    end else begin
      vout_mv = `BB_VOUT_HIGH_BASE_MV + 16'(above_knee * `BB_VOUT_HIGH_STEP_MV); // see R8
    end
  endfunction : vout_mv

  // Readback mux, unmapped addresses read zero
  function automatic logic [7:0] read_mux(
    input logic ctl_hit,
    input logic vd_hit,
    input logic [7:0] ctl_val,
    input logic [7:0] vd_val
  );
    if (ctl_hit) begin
      read_mux = ctl_val;
    end else if (vd_hit) begin
      read_mux = vd_val;
    end else begin
      read_mux = 8'h00;
    end
  endfunction : read_mux

  // Write byte viewed as fields
  assign control_wr = wr_data_i;
  assign volt_dly_wr = wr_data_i;

  // Next values: a write replaces the field, otherwise it holds
  assign softstart_d = wr_control ? control_wr.softstart_time_sel : softstart_q; // see R9
  assign current_limit_d = wr_control ? control_wr.peak_current_limit_sel : current_limit_q;
  assign pulse_stop_d = wr_control ? control_wr.pulse_stop_enable : pulse_stop_q;
  assign discharge_d = wr_control ? control_wr.output_discharge_enable : discharge_q;
  assign output_enable_d = wr_control ? control_wr.regulator_output_enable : output_enable_q;
  assign switch_delay_d = wr_volt_dly ? volt_dly_wr.hysteresis_switch_delay_sel : switch_delay_q;
  assign vout_code_d = wr_volt_dly ? volt_dly_wr.output_voltage_code : vout_code_q;

  // Soft start field, factory reset value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      softstart_q <= SOFTSTART_RESET; // see R9
    end else begin
      softstart_q <= softstart_d;
    end
  end

  // Peak current limit field, fixed reset value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      current_limit_q <= `BB_ILIM_RESET; // see R2
    end else begin
      current_limit_q <= current_limit_d;
    end
  end

  // Pulse stop field, cleared by reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_stop_q <= `BB_STOP_RESET; // see R3
    end else begin
      pulse_stop_q <= pulse_stop_d;
    end
  end

  // Output discharge field, factory reset value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      discharge_q <= DISCHARGE_RESET; // see R4
    end else begin
      discharge_q <= discharge_d;
    end
  end

  // Regulator output enable field, factory reset value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      output_enable_q <= OUTPUT_ENABLE_RESET; // see R5
    end else begin
      output_enable_q <= output_enable_d;
    end
  end

  // Switch delay field, zero delay after reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      switch_delay_q <= `BB_DLY_RESET; // see R6
    end else begin
      switch_delay_q <= switch_delay_d;
    end
  end

  // Output voltage code field, factory reset value
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      vout_code_q <= VOUT_CODE_RESET; // see R9
    end else begin
      vout_code_q <= vout_code_d;
    end
  end

  // Stored fields in register layout
  assign control_rd = {softstart_q, current_limit_q, pulse_stop_q, discharge_q, output_enable_q};
  assign volt_dly_rd = {switch_delay_q, vout_code_q};

  // Readback of the addressed register
  assign rd_data_o = read_mux(sel_control, sel_volt_dly, control_rd, volt_dly_rd); // see R9

  // Soft start selection
  assign softstart_time_sel_o = softstart_q;

  // Peak current limit selection
  assign peak_current_limit_sel_o = current_limit_q;

  // Pulse stop enable
  assign pulse_stop_enable_o = pulse_stop_q; // see R3

  // Output discharge enable
  assign output_discharge_enable_o = discharge_q; // see R4

  // Regulator output enable
  assign regulator_output_enable_o = output_enable_q; // see R5

  // Switch delay selection
  assign hysteresis_switch_delay_sel_o = switch_delay_q;

  // Output voltage code
  assign output_voltage_code_o = vout_code_q;

  // Soft start ramp time in milliseconds
  assign softstart_time_ms_o = softstart_ms(softstart_q); // see R1

  // Peak current limit in milliamps
  assign peak_current_limit_ma_o = ilim_ma(current_limit_q); // see R2

  // Switch delay in microseconds
  assign hysteresis_switch_delay_us_o = delay_us(switch_delay_q); // see R6

  // Output voltage in millivolts
  assign output_voltage_mv_o = vout_mv(vout_code_q); // see R7 see R8

endmodule : buckboost_config_regs
`default_nettype wire

// *** verif/buckboost_config_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module buckboost_config_regs_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic pulse_stop_enable_o,
  input wire logic output_discharge_enable_o,
  input wire logic regulator_output_enable_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [7:0] hysteresis_switch_delay_us_o,
  input wire logic [15:0] softstart_time_ms_o,
  input wire logic [15:0] peak_current_limit_ma_o,
  input wire logic [15:0] output_voltage_mv_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Write strobes per register, delay lookup
  wire logic ctl_wr = wr_en_i && addr_i == 8'h2b;
  wire logic vd_wr = wr_en_i && addr_i == 8'h2c;
  wire logic [31:0] dly_tab = 32'h140a0500;
  property p_ss; ctl_wr |=> softstart_time_ms_o == 16'h1 << 3 * $past(wr_data_i[7:6]); endproperty
  a_ss: assert property (p_ss) else $error("soft start decode wrong");
  property p_il; ctl_wr |=> peak_current_limit_ma_o == 16'h64 * ($past(wr_data_i[5:3]) + 16'h1); endproperty
  a_il: assert property (p_il) else $error("current limit decode wrong");
  property p_en; ctl_wr |=> regulator_output_enable_o == $past(wr_data_i[0]); endproperty
  a_en: assert property (p_en) else $error("output enable wrong");
  property p_ps; ctl_wr |=> pulse_stop_enable_o == $past(wr_data_i[2]); endproperty
  a_ps: assert property (p_ps) else $error("pulse stop wrong");
  property p_dc; ctl_wr |=> output_discharge_enable_o == $past(wr_data_i[1]); endproperty
  a_dc: assert property (p_dc) else $error("discharge enable wrong");
  property p_dl; vd_wr |=> hysteresis_switch_delay_us_o == dly_tab[8 * $past(wr_data_i[7:6]) +: 8]; endproperty
  a_dl: assert property (p_dl) else $error("switch delay wrong");
  property p_vl; vd_wr && wr_data_i[5:0] < 6'h0c |=> output_voltage_mv_o == 16'h0708 + 16'h64 * $past(wr_data_i[5:0]); endproperty
  a_vl: assert property (p_vl) else $error("low voltage wrong");
  property p_vh; vd_wr && wr_data_i[5:0] > 6'h0b |=> output_voltage_mv_o == 16'h0b86 + 16'h32 * ($past(wr_data_i[5:0]) - 16'h0c); endproperty
  a_vh: assert property (p_vh) else $error("high voltage wrong");
  property p_un; (addr_i < 8'h2b || addr_i > 8'h2c) |-> rd_data_o == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read not zero");
  property p_hd; !wr_en_i |=> $stable(output_voltage_mv_o) && $stable(softstart_time_ms_o); endproperty
  a_hd: assert property (p_hd) else $error("field changed without write");
endmodule : buckboost_config_regs_monitor
bind buckboost_config_regs buckboost_config_regs_monitor u_mon (.clk_i, .reset_i, .wr_en_i,
  .pulse_stop_enable_o, .output_discharge_enable_o,
  .regulator_output_enable_o, .addr_i, .wr_data_i, .rd_data_o, .hysteresis_switch_delay_us_o,
  .softstart_time_ms_o, .peak_current_limit_ma_o, .output_voltage_mv_o);
`default_nettype wire

// *** verif/buckboost_config_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module buckboost_config_regs_tb;
  logic clk_i = 1'h0, reset_i = 1'h1, wr_en_i = 1'h0, stp, dis, en;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, us, d;
  logic [15:0] ms, ma, mv;
  int err_count = 0, comparisons = 0;
  buckboost_config_regs u_dut (.clk_i, .reset_i, .addr_i, .wr_en_i, .wr_data_i, .rd_data_o,
    .softstart_time_sel_o(), .softstart_time_ms_o(ms), .peak_current_limit_sel_o(),
    .peak_current_limit_ma_o(ma), .pulse_stop_enable_o(stp), .output_discharge_enable_o(dis),
    .regulator_output_enable_o(en), .hysteresis_switch_delay_sel_o(), .output_voltage_code_o(),
    .hysteresis_switch_delay_us_o(us), .output_voltage_mv_o(mv));
  initial forever #10 clk_i = ~clk_i;
  // One register write, outputs settled on return
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_i); addr_i <= a; wr_data_i <= v; wr_en_i <= 1'h1;
    @(posedge clk_i); wr_en_i <= 1'h0; #1;
  endtask : wr
  task automatic chk(input string n, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin #50000; err_count++; summarize(); end
  // Reset values, every field code of both registers, unmapped access
  initial begin
    repeat (2) @(posedge clk_i); reset_i <= 1'h0; #1;
    chk("ilim rst", 16'h190, ma);
    chk("ss rst", 16'h1, ms);
    chk("rst bits", 16'h0, {13'h0, stp, dis, en});
    chk("dly rst", 16'h0, {8'h0, us});
    chk("mv rst", 16'h0708, mv);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      d = 8'(i * 8 + i % 8); wr(8'h2b, d);
      chk("ss ms", 16'h1 << 3 * i[4:3], ms);
      chk("ilim ma", 16'h64 * (i[2:0] + 1), ma);
      chk("ctl rd", {8'h0, d}, {8'h0, rd_data_o});
      chk("ctl bits", {13'h0, d[2:0]}, {13'h0, stp, dis, en});
    end
    for (int i = 0; i < 64; i++) begin
      d = {i[1:0], i[5:0]}; wr(8'h2c, d);
      chk("mv", i < 12 ? 16'h0708 + 16'h64 * i : 16'h0b86 + 16'h32 * (i - 12), mv);
      chk("dly us", 16'(32'h140a0500 >> 8 * i[1:0]) & 16'hff, {8'h0, us});
      chk("vd rd", {8'h0, d}, {8'h0, rd_data_o});
    end
    wr(8'h2d, 8'h00);
    chk("unmapped rd", 16'h0, {8'h0, rd_data_o});
    chk("mv kept", 16'h157c, mv);
    $display("register tests done");
    wr(8'h2b, 8'hff);
    reset_i <= 1'h1;
    @(posedge clk_i); reset_i <= 1'h0; #1;
    chk("ilim rerst", 16'h190, ma);
    chk("rerst bits", 16'h0, {13'h0, stp, dis, en});
    chk("mv rerst", 16'h0708, mv);
    $display("second reset test done");
    summarize();
  end
endmodule : buckboost_config_regs_tb
`default_nettype wire
